/* File: hdl/tsq_pkg.sv */
// Constants, encodings and configuration structs for the trigger sequencer
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package tsq_pkg;

  //----------------------------------------------------------------------------
  // Sizes
  //----------------------------------------------------------------------------
  localparam int LVL_W = 4;
  localparam int MAX_LEVELS = 12;
  localparam logic [LVL_W-1:0] MIN_LEVELS = 4'h2;
  localparam logic [LVL_W-1:0] STATE_MAX_LEVELS = 4'hC;
  localparam logic [LVL_W-1:0] TIMING_MAX_LEVELS = 4'hA;
  localparam int NUM_PATTERNS = 10;
  localparam int NUM_WINDOWS = 2;
  localparam int NUM_TIMERS = 2;
  localparam int NUM_EDGES = 2;
  localparam int NUM_RES = 16;
  localparam int NUM_PAIRS = 8;
  localparam int POD_W = 16;
  localparam int POD_CNT = 6;
  localparam int DW = POD_W * POD_CNT;
  localparam int WIN_W = 2 * POD_W;
  localparam logic [1:0] NUM_POD_PAIRS = 2'h3;
  localparam int CNT_W = 16;
  localparam int TMR_W = 32;

  //----------------------------------------------------------------------------
  // Resource slots in the group/pair hierarchy
  //----------------------------------------------------------------------------
  localparam int RES_WIN1 = 3;
  localparam int RES_TRANSITION_TERM_ONE = 5;
  localparam int RES_TMR1 = 7;
  localparam int RES_PAT_H = 10;
  localparam int RES_WIN2 = 11;
  localparam int RES_TRANSITION_TERM_TWO = 13;
  localparam int RES_PAT_J = 14;
  localparam int RES_TMR2 = 15;
  localparam logic [NUM_RES-1:0] RES_ALL = 16'hFFFF;

  //----------------------------------------------------------------------------
  // Encodings
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {SEL_OFF, SEL_ON, SEL_NEG} tsq_sel_t;
  typedef enum logic [2:0] {OP_AND, OP_NAND, OP_OR, OP_NOR, OP_XOR, OP_XNOR} tsq_op_t;
  typedef enum logic [1:0] {ST_ALL, ST_NONE, ST_TERM} tsq_store_t;
  typedef enum logic [1:0] {TA_START, TA_STOP, TA_CONT, TA_PAUSE} tsq_tact_t;
  typedef enum logic [1:0] {TP_START, TP_MID, TP_END} tsq_tpos_t;
  typedef enum logic [2:0] {EK_NONE, EK_RISE, EK_FALL, EK_EITHER, EK_GLITCH} tsq_edge_t;
  typedef enum logic [1:0] {SQ_IDLE, SQ_SEARCH, SQ_POST, SQ_DONE} tsq_seq_t;

  //----------------------------------------------------------------------------
  // Configuration carriers
  //----------------------------------------------------------------------------
  typedef struct packed {
    tsq_sel_t [NUM_RES-1:0] sel;
    tsq_op_t [NUM_PAIRS-1:0] op;
    logic [1:0] group_or;
    logic top_or;
  } tsq_expr_t;

  typedef struct packed {
    tsq_expr_t adv_expr;
    tsq_expr_t else_expr;
    tsq_expr_t store_expr;
    tsq_store_t store_mode;
    logic [LVL_W-1:0] else_target;
    logic adv_by_time;
    logic [CNT_W-1:0] adv_count;
    logic is_trigger;
    tsq_tact_t [NUM_TIMERS-1:0] tmr_act;
  } tsq_level_t;

  typedef struct packed {
    logic [DW-1:0] value;
    logic [DW-1:0] mask;
  } tsq_pattern_t;

  typedef struct packed {
    logic [1:0] pod_pair;
    logic [WIN_W-1:0] low;
    logic [WIN_W-1:0] high;
  } tsq_window_t;

  typedef struct packed {
    logic [DW-1:0] chan_mask;
    tsq_edge_t kind;
  } tsq_edgecfg_t;

endpackage

/* File: hdl/tsq_sequencer.sv */
// Trigger sequencer: term resources, level stepping, storage and trigger lock
`timescale 1ns/1ps
module tsq_sequencer #(
  parameter int MEM_AW = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ARM,
  input wire logic MODE_TIMING,
  input wire logic [tsq_pkg::LVL_W-1:0] NUM_LEVELS,
  input wire logic BRANCH_NOT_STORED,
  input wire tsq_pkg::tsq_tpos_t TRIG_POS,
  input wire tsq_pkg::tsq_level_t [tsq_pkg::MAX_LEVELS-1:0] LEVEL_CFG,
  input wire tsq_pkg::tsq_pattern_t [tsq_pkg::NUM_PATTERNS-1:0] PATTERN_CFG,
  input wire tsq_pkg::tsq_window_t [tsq_pkg::NUM_WINDOWS-1:0] WINDOW_CFG,
  input wire tsq_pkg::tsq_edgecfg_t [tsq_pkg::NUM_EDGES-1:0] EDGE_CFG,
  input wire logic [tsq_pkg::NUM_TIMERS-1:0][tsq_pkg::TMR_W-1:0] TIMER_PRESET,
  input wire logic [tsq_pkg::DW-1:0] POD_DATA,
  input wire logic [tsq_pkg::DW-1:0] POD_GLITCH,
  output logic [tsq_pkg::LVL_W-1:0] LEVEL,
  output logic RUNNING,
  output logic STORE_STROBE,
  output logic [MEM_AW-1:0] STORE_ADDR,
  output logic [tsq_pkg::DW-1:0] STORE_DATA,
  output logic TRIGGERED,
  output logic [MEM_AW-1:0] TRIG_ADDR,
  output logic ACQ_DONE
);

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    tsq_pkg::tsq_seq_t seq;
    logic [tsq_pkg::LVL_W-1:0] level;
    logic [tsq_pkg::CNT_W-1:0] cnt;
    logic [tsq_pkg::NUM_TIMERS-1:0][tsq_pkg::TMR_W-1:0] tmr;
    logic [tsq_pkg::NUM_TIMERS-1:0] tmr_run;
    logic trig_seen;
    logic [MEM_AW-1:0] wr_addr;
    logic [MEM_AW-1:0] post_cnt;
    logic [MEM_AW-1:0] trig_addr;
    logic [MEM_AW-1:0] store_addr;
    logic store;
    logic [tsq_pkg::DW-1:0] store_data;
    logic [tsq_pkg::DW-1:0] d1;
    logic [tsq_pkg::DW-1:0] d2;
    logic [tsq_pkg::DW-1:0] prev;
    logic [tsq_pkg::DW-1:0] g1;
    logic [tsq_pkg::DW-1:0] g2;
    logic running;
    logic done;
  } tsq_state_t;

  localparam logic [MEM_AW-1:0] POST_FULL = '1;
  localparam logic [MEM_AW-1:0] POST_HALF = MEM_AW'(1) << (MEM_AW - 1);
  localparam logic [MEM_AW-1:0] POST_NONE = '0;

  tsq_state_t q;
  tsq_state_t d;

  //----------------------------------------------------------------------------
  // Expression evaluation through the fixed pair/group hierarchy
  //----------------------------------------------------------------------------
  // Off resources drop out; a pair with one member passes it through unchanged
  function automatic logic eval_term(input tsq_pkg::tsq_expr_t e,
                                     input logic [tsq_pkg::NUM_RES-1:0] pos,
                                     input logic [tsq_pkg::NUM_RES-1:0] neg,
                                     input logic [tsq_pkg::NUM_RES-1:0] avail);
    logic [tsq_pkg::NUM_RES-1:0] v = '0;
    logic [tsq_pkg::NUM_RES-1:0] u = '0;
    logic [tsq_pkg::NUM_PAIRS-1:0] pv = '0;
    logic [tsq_pkg::NUM_PAIRS-1:0] pu = '0;
    logic [1:0] gv = '0;
    logic [1:0] gu = '0;
    for (int k = 0; k < tsq_pkg::NUM_RES; k++) begin
      u[k] = avail[k] && (e.sel[k] != tsq_pkg::SEL_OFF);
      v[k] = (e.sel[k] == tsq_pkg::SEL_NEG) ? neg[k] : pos[k];
    end
    for (int p = 0; p < tsq_pkg::NUM_PAIRS; p++) begin
      pu[p] = u[2*p] | u[2*p+1];
      if (u[2*p] && u[2*p+1]) begin
        case (e.op[p])
          tsq_pkg::OP_AND: pv[p] = v[2*p] & v[2*p+1];
          tsq_pkg::OP_NAND: pv[p] = ~(v[2*p] & v[2*p+1]);
          tsq_pkg::OP_OR: pv[p] = v[2*p] | v[2*p+1];
          tsq_pkg::OP_NOR: pv[p] = ~(v[2*p] | v[2*p+1]);
          tsq_pkg::OP_XOR: pv[p] = v[2*p] ^ v[2*p+1];
          tsq_pkg::OP_XNOR: pv[p] = ~(v[2*p] ^ v[2*p+1]);
          default: pv[p] = v[2*p] & v[2*p+1];
        endcase
      end else begin
        pv[p] = u[2*p] ? v[2*p] : v[2*p+1];
      end
    end
    for (int g = 0; g < 2; g++) begin
      gu[g] = |pu[4*g +: 4];
      gv[g] = e.group_or[g] ? |(pv[4*g +: 4] & pu[4*g +: 4])
                            : &(pv[4*g +: 4] | ~pu[4*g +: 4]);
    end
    // An expression with nothing selected never fires
    return (|gu) && (e.top_or ? |(gv & gu) : &(gv | ~gu));
  endfunction

  //----------------------------------------------------------------------------
  // Resource terms
  //----------------------------------------------------------------------------
  logic [tsq_pkg::NUM_PATTERNS-1:0] pat_hit;
  logic [tsq_pkg::NUM_WINDOWS-1:0] win_in;
  logic [tsq_pkg::NUM_EDGES-1:0] edge_hit;
  logic [tsq_pkg::NUM_TIMERS-1:0] tmr_lt;
  logic [tsq_pkg::NUM_TIMERS-1:0] tmr_gt;

  // Masked compare ANDs all label bits within one sample
  for (genvar i = 0; i < tsq_pkg::NUM_PATTERNS; i++) begin : g_pat
    assign pat_hit[i] = ~|((q.d2 ^ PATTERN_CFG[i].value) & PATTERN_CFG[i].mask);
  end

  // Windows only see one aligned pod pair; a bad pair index never matches
  for (genvar i = 0; i < tsq_pkg::NUM_WINDOWS; i++) begin : g_win
    logic [tsq_pkg::WIN_W-1:0] wv;
    assign wv = (WINDOW_CFG[i].pod_pair == 2'h0) ? q.d2[0 +: tsq_pkg::WIN_W] :
                (WINDOW_CFG[i].pod_pair == 2'h1) ? q.d2[tsq_pkg::WIN_W +: tsq_pkg::WIN_W] :
                q.d2[2*tsq_pkg::WIN_W +: tsq_pkg::WIN_W];
    assign win_in[i] = (WINDOW_CFG[i].pod_pair < tsq_pkg::NUM_POD_PAIRS)
                       && (wv >= WINDOW_CFG[i].low) && (wv <= WINDOW_CFG[i].high);
  end

  // Any selected channel satisfies the edge term; glitches come from the front end
  for (genvar i = 0; i < tsq_pkg::NUM_EDGES; i++) begin : g_edge
    logic [tsq_pkg::DW-1:0] ev;
    always_comb begin
      case (EDGE_CFG[i].kind)
        tsq_pkg::EK_RISE: ev = q.d2 & ~q.prev;
        tsq_pkg::EK_FALL: ev = ~q.d2 & q.prev;
        tsq_pkg::EK_EITHER: ev = q.d2 ^ q.prev;
        tsq_pkg::EK_GLITCH: ev = q.g2;
        default: ev = '0;
      endcase
    end
    assign edge_hit[i] = |(ev & EDGE_CFG[i].chan_mask);
  end

  // Timers compare against their presets both ways
  for (genvar i = 0; i < tsq_pkg::NUM_TIMERS; i++) begin : g_tmr
    assign tmr_lt[i] = q.tmr[i] < TIMER_PRESET[i];
    assign tmr_gt[i] = q.tmr[i] > TIMER_PRESET[i];
  end

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  logic [tsq_pkg::NUM_RES-1:0] res_pos;
  logic [tsq_pkg::NUM_RES-1:0] res_neg;
  logic [tsq_pkg::NUM_RES-1:0] avail;
  logic [tsq_pkg::LVL_W-1:0] lvl_max;
  logic [tsq_pkg::LVL_W-1:0] last;
  logic [tsq_pkg::LVL_W-1:0] tgt;
  logic [tsq_pkg::LVL_W-1:0] enter_lvl;
  logic [tsq_pkg::CNT_W:0] need;
  logic [tsq_pkg::CNT_W:0] seen;
  tsq_pkg::tsq_level_t cfg;
  logic adv_t;
  logic else_t;
  logic store_t;
  logic is_last;
  logic trig_here;
  logic adv_met;
  logic fire_trig;
  logic enter;
  logic keep;

  always_comb begin
    d = q;
    // Pin inputs: second flop is the only reader of the first
    d.d1 = POD_DATA;
    d.d2 = q.d1;
    d.g1 = POD_GLITCH;
    d.g2 = q.g1;
    d.prev = q.d2;
    d.store = 1'b0;
    // Slots follow the group/pair table; off by default through sel
    res_pos = {tmr_lt[1], pat_hit[9], edge_hit[1], pat_hit[8], win_in[1], pat_hit[7],
               pat_hit[6], pat_hit[5], tmr_lt[0], pat_hit[4], edge_hit[0], pat_hit[3],
               win_in[0], pat_hit[2], pat_hit[1], pat_hit[0]};
    res_neg = ~res_pos;
    res_neg[tsq_pkg::RES_TMR1] = tmr_gt[0];
    res_neg[tsq_pkg::RES_TMR2] = tmr_gt[1];
    avail = tsq_pkg::RES_ALL;
    if (q.level == '0) begin
      avail[tsq_pkg::RES_TMR1] = 1'b0;
      avail[tsq_pkg::RES_TMR2] = 1'b0;
    end
    if (MODE_TIMING) begin
      avail[tsq_pkg::RES_PAT_H] = 1'b0;
      avail[tsq_pkg::RES_PAT_J] = 1'b0;
    end else begin
      avail[tsq_pkg::RES_TRANSITION_TERM_ONE] = 1'b0;
      avail[tsq_pkg::RES_TRANSITION_TERM_TWO] = 1'b0;
    end
    // Level count clamped to the mode's range
    lvl_max = MODE_TIMING ? tsq_pkg::TIMING_MAX_LEVELS : tsq_pkg::STATE_MAX_LEVELS;
    last = (NUM_LEVELS < tsq_pkg::MIN_LEVELS) ? tsq_pkg::MIN_LEVELS - 4'h1 :
           (NUM_LEVELS > lvl_max) ? lvl_max - 4'h1 : NUM_LEVELS - 4'h1;
    cfg = LEVEL_CFG[q.level];
    is_last = q.level >= last;
    // One evaluation of every term per sample
    adv_t = eval_term(cfg.adv_expr, res_pos, res_neg, avail);
    else_t = eval_term(cfg.else_expr, res_pos, res_neg, avail);
    store_t = eval_term(cfg.store_expr, res_pos, res_neg, avail);
    trig_here = MODE_TIMING ? is_last : (cfg.is_trigger && !is_last);
    need = (cfg.adv_count == '0) ? 17'h0_0001 : {1'b0, cfg.adv_count};
    seen = {1'b0, q.cnt} + 17'h0_0001;
    // Final level advances only when it is the timing trigger
    adv_met = adv_t && (seen >= need) && (!is_last || (trig_here && !q.trig_seen));
    fire_trig = adv_met && trig_here && !q.trig_seen;
    // Else target past the programmed levels keeps the current level, backward only from the last
    tgt = (cfg.else_target > last || (is_last && cfg.else_target > q.level)) ? q.level
          : cfg.else_target;
    enter = 1'b0;
    enter_lvl = q.level;
    keep = 1'b0;
    case (q.seq)
      tsq_pkg::SQ_SEARCH, tsq_pkg::SQ_POST: begin
        if (adv_met) begin
          d.cnt = '0;
          if (!is_last) begin
            enter = 1'b1;
            enter_lvl = q.level + 4'h1;
          end
        end else if (else_t) begin
          d.cnt = '0;
          enter = 1'b1;
          enter_lvl = tgt;
        end else if (adv_t) begin
          d.cnt = q.cnt + 16'h0001;
        end else if (cfg.adv_by_time) begin
          d.cnt = '0;
        end
        d.level = enter_lvl;
        // Current level's qualifier; branch samples kept unless suppressed
        case (cfg.store_mode)
          tsq_pkg::ST_ALL: keep = 1'b1;
          tsq_pkg::ST_TERM: keep = store_t;
          default: keep = 1'b0;
        endcase
        keep = keep || ((adv_met || else_t || adv_t) && !BRANCH_NOT_STORED) || fire_trig;
        if (keep) begin
          d.store = 1'b1;
          d.store_addr = q.wr_addr;
          d.store_data = q.d2;
          d.wr_addr = q.wr_addr + MEM_AW'(1);
        end
        // Trigger sample's address is locked, then fill the rest
        if (fire_trig) begin
          d.trig_seen = 1'b1;
          d.trig_addr = q.wr_addr;
          d.seq = tsq_pkg::SQ_POST;
          case (TRIG_POS)
            tsq_pkg::TP_START: d.post_cnt = POST_FULL;
            tsq_pkg::TP_MID: d.post_cnt = POST_HALF;
            default: d.post_cnt = POST_NONE;
          endcase
          if (TRIG_POS == tsq_pkg::TP_END) begin
            d.seq = tsq_pkg::SQ_DONE;
          end
        end else if (q.seq == tsq_pkg::SQ_POST && keep) begin
          d.post_cnt = q.post_cnt - MEM_AW'(1);
          if (q.post_cnt == MEM_AW'(1) || q.post_cnt == '0) begin
            d.seq = tsq_pkg::SQ_DONE;
          end
        end
      end
      default: ;
    endcase
    // Timers run freely when enabled and saturate rather than wrap
    for (int t = 0; t < tsq_pkg::NUM_TIMERS; t++) begin
      if (q.tmr_run[t] && q.tmr[t] != '1) begin
        d.tmr[t] = q.tmr[t] + 32'h0000_0001;
      end
    end
    if (ARM) begin
      d.seq = tsq_pkg::SQ_SEARCH;
      d.cnt = '0;
      d.trig_seen = 1'b0;
      d.wr_addr = '0;
      d.post_cnt = '0;
      d.store = 1'b0;
      enter = 1'b1;
      enter_lvl = '0;
      d.level = '0;
    end
    // Status kept in flops so the outputs carry no decode logic
    d.running = (d.seq == tsq_pkg::SQ_SEARCH) || (d.seq == tsq_pkg::SQ_POST);
    d.done = (d.seq == tsq_pkg::SQ_DONE);
    // Entry actions of the level being entered
    if (enter) begin
      for (int t = 0; t < tsq_pkg::NUM_TIMERS; t++) begin
        case (LEVEL_CFG[enter_lvl].tmr_act[t])
          tsq_pkg::TA_START: begin
            d.tmr[t] = '0;
            d.tmr_run[t] = 1'b1;
          end
          tsq_pkg::TA_STOP: begin
            d.tmr[t] = '0;
            d.tmr_run[t] = 1'b0;
          end
          tsq_pkg::TA_CONT: d.tmr_run[t] = 1'b1;
          default: d.tmr_run[t] = 1'b0;
        endcase
      end
    end
  end

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  //----------------------------------------------------------------------------
  // Outputs straight from flops
  //----------------------------------------------------------------------------
  assign LEVEL = q.level;
  assign RUNNING = q.running;
  assign STORE_STROBE = q.store;
  assign STORE_ADDR = q.store_addr;
  assign STORE_DATA = q.store_data;
  assign TRIGGERED = q.trig_seen;
  assign TRIG_ADDR = q.trig_addr;
  assign ACQ_DONE = q.done;

endmodule // tsq_sequencer

/* File: dv/tsq_pod_model.sv */
// Probe pod model driving sampled target signals
`timescale 1ns/1ps
module tsq_pod_model (
  input wire logic CLK,
  output logic [tsq_pkg::DW-1:0] POD_DATA,
  output logic [tsq_pkg::DW-1:0] POD_GLITCH
);
  // Pods always drive; glitch flags stay quiet in this model
  initial begin
    POD_DATA = '0;
    POD_GLITCH = '0;
  end
  // One value for n samples, launched just after each edge
  task automatic show(input logic [tsq_pkg::DW-1:0] v, input int n);
    repeat (n) begin
      @(posedge CLK);
      #1 POD_DATA = v;
    end
  endtask
endmodule // tsq_pod_model

/* File: dv/tsq_sequencer_asserts.sv */
// Port-level checker for the trigger sequencer
`timescale 1ns/1ps
module tsq_sequencer_asserts #(
  parameter int MEM_AW = 16
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ARM,
  input wire logic MODE_TIMING,
  input wire logic [tsq_pkg::LVL_W-1:0] NUM_LEVELS,
  input wire tsq_pkg::tsq_tpos_t TRIG_POS,
  input wire logic [tsq_pkg::LVL_W-1:0] LEVEL,
  input wire logic RUNNING,
  input wire logic STORE_STROBE,
  input wire logic [MEM_AW-1:0] STORE_ADDR,
  input wire logic TRIGGERED,
  input wire logic [MEM_AW-1:0] TRIG_ADDR,
  input wire logic ACQ_DONE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----
  // Steps
  // ----
  sequence s_trig;
    $rose(TRIGGERED);
  endsequence
  sequence s_idle2;
    !RUNNING ##1 !RUNNING;
  endsequence
  property p_lvl_range;
    RUNNING |-> LEVEL < (MODE_TIMING ? tsq_pkg::TIMING_MAX_LEVELS : tsq_pkg::STATE_MAX_LEVELS);
  endproperty
  a_lvl_range: assert property (p_lvl_range) else $error("level past mode limit");
  property p_arm;
    ARM |=> RUNNING && LEVEL == 4'h0;
  endproperty
  a_arm: assert property (p_arm) else $error("arm did not restart at level zero");
  property p_sticky;
    TRIGGERED && !ARM |=> TRIGGERED && $stable(TRIG_ADDR);
  endproperty
  a_sticky: assert property (p_sticky) else $error("trigger position not held");
  property p_end;
    s_trig ##0 TRIG_POS == tsq_pkg::TP_END |-> ACQ_DONE;
  endproperty
  a_end: assert property (p_end) else $error("end trigger did not lock");
  property p_early;
    s_trig ##0 TRIG_POS != tsq_pkg::TP_END |-> !ACQ_DONE;
  endproperty
  a_early: assert property (p_early) else $error("memory locked too early");
  property p_trig_store;
    s_trig |-> STORE_STROBE && STORE_ADDR == TRIG_ADDR;
  endproperty
  a_trig_store: assert property (p_trig_store) else $error("trigger sample not stored");
  property p_quiet;
    s_idle2 |-> !STORE_STROBE;
  endproperty
  a_quiet: assert property (p_quiet) else $error("store while idle");
  property p_next;
    s_trig ##0 !MODE_TIMING |-> LEVEL == $past(LEVEL) + 4'h1;
  endproperty
  a_next: assert property (p_next) else $error("no advance after trigger");
  property p_last;
    s_trig ##0 MODE_TIMING |-> $past(LEVEL) == NUM_LEVELS - 4'h1;
  endproperty
  a_last: assert property (p_last) else $error("timing trigger off last level");
  property p_lock;
    ACQ_DONE && !ARM |=> ACQ_DONE && !RUNNING;
  endproperty
  a_lock: assert property (p_lock) else $error("memory lock lost");
endmodule // tsq_sequencer_asserts
bind tsq_sequencer tsq_sequencer_asserts #(.MEM_AW(MEM_AW)) tsq_sequencer_asserts_inst (
  .CLK(CLK), .RST_N(RST_N), .ARM(ARM), .MODE_TIMING(MODE_TIMING), .NUM_LEVELS(NUM_LEVELS),
  .TRIG_POS(TRIG_POS), .LEVEL(LEVEL), .RUNNING(RUNNING), .STORE_STROBE(STORE_STROBE),
  .STORE_ADDR(STORE_ADDR), .TRIGGERED(TRIGGERED), .TRIG_ADDR(TRIG_ADDR), .ACQ_DONE(ACQ_DONE));

/* File: dv/tsq_sequencer_test.sv */
// Self-checking bench for the trigger sequencer
`timescale 1ns/1ps
module tsq_sequencer_test;
  localparam int AW = 4;
  localparam logic [95:0] PA = 96'h0001;
  localparam logic [95:0] PB = 96'h0003;
  localparam logic [95:0] PC = 96'h0002;
  logic CLK, RST_N, ARM, MODE_TIMING, BRANCH_NOT_STORED, RUNNING, STORE_STROBE, TRIGGERED, ACQ_DONE;
  logic [3:0] NUM_LEVELS, LEVEL;
  tsq_pkg::tsq_tpos_t TRIG_POS;
  tsq_pkg::tsq_level_t [tsq_pkg::MAX_LEVELS-1:0] LEVEL_CFG;
  tsq_pkg::tsq_pattern_t [tsq_pkg::NUM_PATTERNS-1:0] PATTERN_CFG;
  tsq_pkg::tsq_window_t [tsq_pkg::NUM_WINDOWS-1:0] WINDOW_CFG;
  tsq_pkg::tsq_edgecfg_t [tsq_pkg::NUM_EDGES-1:0] EDGE_CFG;
  logic [tsq_pkg::NUM_TIMERS-1:0][tsq_pkg::TMR_W-1:0] TIMER_PRESET;
  logic [tsq_pkg::DW-1:0] POD_DATA, POD_GLITCH;
  logic [AW-1:0] STORE_ADDR, TRIG_ADDR, last_addr;
  int n_errors, check_count, n_store;
  tsq_sequencer #(.MEM_AW(AW)) tsq_sequencer_inst (.CLK(CLK), .RST_N(RST_N), .ARM(ARM),
    .MODE_TIMING(MODE_TIMING), .NUM_LEVELS(NUM_LEVELS), .BRANCH_NOT_STORED(BRANCH_NOT_STORED),
    .TRIG_POS(TRIG_POS), .LEVEL_CFG(LEVEL_CFG), .PATTERN_CFG(PATTERN_CFG),
    .WINDOW_CFG(WINDOW_CFG), .EDGE_CFG(EDGE_CFG), .TIMER_PRESET(TIMER_PRESET),
    .POD_DATA(POD_DATA), .POD_GLITCH(POD_GLITCH), .LEVEL(LEVEL), .RUNNING(RUNNING),
    .STORE_STROBE(STORE_STROBE), .STORE_ADDR(STORE_ADDR), .STORE_DATA(),
    .TRIGGERED(TRIGGERED), .TRIG_ADDR(TRIG_ADDR), .ACQ_DONE(ACQ_DONE));
  tsq_pod_model tsq_pod_model_inst (.CLK(CLK), .POD_DATA(POD_DATA), .POD_GLITCH(POD_GLITCH));
  // Sample clock
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Count writes; the last address shows where filling stopped
  always @(posedge CLK) begin
    if (STORE_STROBE === 1'b1) begin
      n_store++;
      last_addr = STORE_ADDR;
    end
  end
  // ----
  // Tasks
  // ----
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait: 0 level, 1 trigger, 2 lock; a hang ends the run
  task automatic wait_for(input int k, input logic [3:0] e);
    int i;
    for (i = 0; i < 40; i++) begin
      if ((k == 0 && LEVEL === e) || (k == 1 && TRIGGERED === 1'b1)) break;
      if (k == 2 && ACQ_DONE === 1'b1) break;
      @(posedge CLK);
      #1;
    end
    if (i == 40) begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic arm();
    @(posedge CLK);
    #1 ARM = 1'b1;
    @(posedge CLK);
    #1 ARM = 1'b0;
    n_store = 0;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    RST_N = 1'b0;
    ARM = 1'b0;
    MODE_TIMING = 1'b0;
    NUM_LEVELS = 4'h3;
    BRANCH_NOT_STORED = 1'b0;
    TRIG_POS = tsq_pkg::TP_END;
    LEVEL_CFG = '0;
    WINDOW_CFG = '0;
    EDGE_CFG = '0;
    TIMER_PRESET = '0;
    n_errors = 0;
    check_count = 0;
    n_store = 0;
    // Patterns a, b, c on the low byte only
    PATTERN_CFG = '0;
    PATTERN_CFG[0] = {PA, 96'h00FF};
    PATTERN_CFG[1] = {PB, 96'h00FF};
    PATTERN_CFG[2] = {PC, 96'h00FF};
    // Second occurrence of a advances; c triggers; only branch samples stored
    LEVEL_CFG[0].adv_expr.sel[0] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].adv_count = 16'h0002;
    LEVEL_CFG[0].store_mode = tsq_pkg::ST_NONE;
    LEVEL_CFG[1].adv_expr.sel[2] = tsq_pkg::SEL_ON;
    LEVEL_CFG[1].is_trigger = 1'b1;
    LEVEL_CFG[1].store_mode = tsq_pkg::ST_NONE;
    repeat (3) @(posedge CLK);
    #1 RST_N = 1'b1;
    arm();
    tsq_pod_model_inst.show(PA, 1);
    tsq_pod_model_inst.show('0, 4);
    chk(LEVEL, 16'h0000);
    tsq_pod_model_inst.show(PA, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(0, 4'h1);
    chk(LEVEL, 16'h0001);
    tsq_pod_model_inst.show(PC, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(0, 4'h2);
    chk(TRIGGERED, 16'h0001);
    chk(TRIG_ADDR, 16'h0002);
    chk(ACQ_DONE, 16'h0001);
    tsq_pod_model_inst.show('0, 4);
    chk(16'(n_store), 16'h0003);
    // Else on b: forward to level 2, then back from the last level
    BRANCH_NOT_STORED = 1'b1;
    LEVEL_CFG[0].else_expr.sel[1] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].else_target = 4'h2;
    LEVEL_CFG[2].else_expr.sel[1] = tsq_pkg::SEL_ON;
    LEVEL_CFG[2].store_mode = tsq_pkg::ST_NONE;
    arm();
    tsq_pod_model_inst.show(PB, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(0, 4'h2);
    chk(LEVEL, 16'h0002);
    tsq_pod_model_inst.show(PB, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(0, 4'h0);
    chk(LEVEL, 16'h0000);
    chk(16'(n_store), 16'h0000);
    chk(TRIGGERED, 16'h0000);
    // Timing mode: stable a for 3 samples, trigger in the last level, mid fill
    LEVEL_CFG = '0;
    MODE_TIMING = 1'b1;
    NUM_LEVELS = 4'h2;
    TRIG_POS = tsq_pkg::TP_MID;
    BRANCH_NOT_STORED = 1'b0;
    LEVEL_CFG[0].adv_expr.sel[0] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].adv_by_time = 1'b1;
    LEVEL_CFG[0].adv_count = 16'h0003;
    LEVEL_CFG[1].adv_expr.sel[2] = tsq_pkg::SEL_ON;
    arm();
    tsq_pod_model_inst.show(PA, 2);
    tsq_pod_model_inst.show('0, 4);
    chk(LEVEL, 16'h0000);
    tsq_pod_model_inst.show(PA, 3);
    tsq_pod_model_inst.show('0, 1);
    wait_for(0, 4'h1);
    chk(LEVEL, 16'h0001);
    tsq_pod_model_inst.show(PC, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(1, 4'h0);
    chk(ACQ_DONE, 16'h0000);
    wait_for(2, 4'h0);
    chk(TRIG_ADDR, 16'h000F);
    chk(RUNNING, 16'h0000);
    // Last strobe is only counted at the edge after the lock
    @(posedge CLK);
    #1;
    chk(last_addr, 16'h0007);
    chk(16'(n_store), 16'h0018);
    // State mode, start position: window one triggers, only a xor b kept before it
    LEVEL_CFG = '0;
    MODE_TIMING = 1'b0;
    TRIG_POS = tsq_pkg::TP_START;
    BRANCH_NOT_STORED = 1'b1;
    WINDOW_CFG[0].low = 32'h0000_0010;
    WINDOW_CFG[0].high = 32'h0000_0020;
    LEVEL_CFG[0].adv_expr.sel[3] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].is_trigger = 1'b1;
    LEVEL_CFG[0].store_mode = tsq_pkg::ST_TERM;
    LEVEL_CFG[0].store_expr.sel[0] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].store_expr.sel[1] = tsq_pkg::SEL_ON;
    LEVEL_CFG[0].store_expr.op[0] = tsq_pkg::OP_XOR;
    arm();
    tsq_pod_model_inst.show(96'h0040, 1);
    tsq_pod_model_inst.show(PA, 1);
    tsq_pod_model_inst.show(96'h0018, 1);
    tsq_pod_model_inst.show('0, 1);
    wait_for(2, 4'h0);
    chk(TRIG_ADDR, 16'h0001);
    chk(LEVEL, 16'h0001);
    @(posedge CLK);
    #1;
    chk(last_addr, 16'h0000);
    chk(16'(n_store), 16'h0011);
    conclude();
  end
endmodule // tsq_sequencer_test
